//--- hdl/oprb_port_bank.sv
// Top of the opto relay port bank: byte registers, relays, interrupt
`timescale 1ns/1ns

module oprb_port_bank
(
  // Clock and reset
  input  wire logic       clock_in,
  input  wire logic       arst_n_in,
  // Host byte bus
  input  wire logic [2:0] io_addr_in,
  input  wire logic [7:0] io_wdata_in,
  input  wire logic       io_wr_in,
  input  wire logic       io_rd_in,
  output logic      [7:0] io_rdata_out,
  output logic            io_rvalid_out,
  // Sensor inputs, active low
  input  wire logic [7:0] sensor_first_bits_in,
  input  wire logic [7:0] sensor_second_bits_in,
  // Relay drives, 1 closes the relay
  output logic      [7:0] relay_first_bits_out,
  output logic      [7:0] relay_second_bits_out,
  // Host interrupt request
  output logic            irq_out
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed
  {
    logic [7:0] relay_first;            // Drive of first relay group
    logic [7:0] relay_second;           // Drive of second relay group
    logic       interrupt_enable_bit;   // Gates the request
    logic       interrupt_pending_bit;  // Sticky trigger flag
    logic       trigger_type_select;    // 0 level, 1 edge
    logic       trigger_polarity_select;// 0 low/falling, 1 high/rising
    logic [7:0] rdata;                  // Read data holding register
    logic       rvalid;                 // Read answer strobe
    logic       irq;                    // Request to the host
  } oprb_state_t;

  oprb_state_t state;       // Registered state
  oprb_state_t next_state;  // Next state

  // ---------------------------------------------------------------
  // Decode and helpers
  // ---------------------------------------------------------------
  logic       trig_event;   // Trigger condition this cycle
  logic [7:0] ctrl_view;    // Control/status byte as read
  logic [7:0] read_byte;    // Selected read byte
  logic       wr_relay1;    // Write to first relay port
  logic       wr_relay2;    // Write to second relay port
  logic       wr_ctrl;      // Write to control/status
  logic       rd_ctrl;      // Read of control/status

  // Only the relay ports and the control byte decode writes
  assign wr_relay1 = io_wr_in && (io_addr_in == oprb_pkg::OFF_RELAY_FIRST);
  assign wr_relay2 = io_wr_in && (io_addr_in == oprb_pkg::OFF_RELAY_SECOND);
  assign wr_ctrl   = io_wr_in && (io_addr_in == oprb_pkg::OFF_IRQ_CTRL);
  assign rd_ctrl   = io_rd_in && (io_addr_in == oprb_pkg::OFF_IRQ_CTRL);

  // Control byte layout, middle bits zero
  always_comb
  begin
    ctrl_view                               = oprb_pkg::READ_ZERO;
    ctrl_view[oprb_pkg::BIT_IRQ_ENABLE]     = state.interrupt_enable_bit;
    ctrl_view[oprb_pkg::BIT_IRQ_PENDING]    = state.interrupt_pending_bit;
    ctrl_view[oprb_pkg::BIT_TRIG_TYPE]      = state.trigger_type_select;
    ctrl_view[oprb_pkg::BIT_TRIG_POL]       = state.trigger_polarity_select;
  end

  // ---------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------
  // Trigger detector on the first sensor bit 0
  oprb_trigger u_trigger
  (
    .clock_in     (clock_in),
    .arst_n_in    (arst_n_in),
    .src_in       (sensor_first_bits_in[oprb_pkg::BIT_IRQ_SOURCE]),
    .trig_type_in (state.trigger_type_select),
    .trig_pol_in  (state.trigger_polarity_select),
    .event_out    (trig_event)
  );

  // Read data selection
  oprb_read_mux u_read_mux
  (
    .addr_in          (io_addr_in),
    .sensor_first_in  (sensor_first_bits_in),
    .sensor_second_in (sensor_second_bits_in),
    .relay_first_in   (state.relay_first),
    .relay_second_in  (state.relay_second),
    .ctrl_in          (ctrl_view),
    .data_out         (read_byte)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    next_state        = state;
    next_state.rvalid = io_rd_in;
    // Read answer captured from the selected byte
    if (io_rd_in)
    begin
      next_state.rdata = read_byte;
    end
    // Relay drive writes; other offsets leave the drives alone
    if (wr_relay1)
    begin
      next_state.relay_first = io_wdata_in;
    end
    if (wr_relay2)
    begin
      next_state.relay_second = io_wdata_in;
    end
    // Control write: enable and mode, pending bit not writable
    if (wr_ctrl)
    begin
      next_state.interrupt_enable_bit    = io_wdata_in[oprb_pkg::BIT_IRQ_ENABLE];
      next_state.trigger_type_select     = io_wdata_in[oprb_pkg::BIT_TRIG_TYPE];
      next_state.trigger_polarity_select = io_wdata_in[oprb_pkg::BIT_TRIG_POL];
    end
    // Read of control clears pending; a live trigger sets it again
    if (rd_ctrl)
    begin
      next_state.interrupt_pending_bit = 1'b0;
    end
    if (trig_event)
    begin
      next_state.interrupt_pending_bit = 1'b1;
    end
    // Request follows the new enable and pending values
    next_state.irq = next_state.interrupt_enable_bit && next_state.interrupt_pending_bit;
  end

  // Registers the state; reset releases every relay
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state.relay_first             <= oprb_pkg::RST_RELAY;
      state.relay_second            <= oprb_pkg::RST_RELAY;
      state.interrupt_enable_bit    <= oprb_pkg::RST_ENABLE;
      state.interrupt_pending_bit   <= oprb_pkg::RST_PENDING;
      state.trigger_type_select     <= oprb_pkg::RST_MODE[oprb_pkg::BIT_TRIG_TYPE];
      state.trigger_polarity_select <= oprb_pkg::RST_MODE[oprb_pkg::BIT_TRIG_POL];
      state.rdata                   <= oprb_pkg::READ_ZERO;
      state.rvalid                  <= 1'b0;
      state.irq                     <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign io_rdata_out          = state.rdata;
  assign io_rvalid_out         = state.rvalid;
  assign relay_first_bits_out  = state.relay_first;
  assign relay_second_bits_out = state.relay_second;
  assign irq_out               = state.irq;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);

  // Read request at a given offset
  sequence s_read_at(logic [2:0] off);
    io_rd_in && (io_addr_in == off);
  endsequence

  // Write request at a given offset
  sequence s_write_at(logic [2:0] off);
    io_wr_in && (io_addr_in == off);
  endsequence

  a_relay_write_first: assert property (s_write_at(oprb_pkg::OFF_RELAY_FIRST) |=>
    relay_first_bits_out == $past(io_wdata_in))
    else $error("first relay group did not take written byte");

  a_relay_write_second: assert property (s_write_at(oprb_pkg::OFF_RELAY_SECOND) |=>
    relay_second_bits_out == $past(io_wdata_in))
    else $error("second relay group did not take written byte");

  a_readonly_write_ignored: assert property (io_wr_in && !wr_relay1 && !wr_relay2 |=>
    $stable(relay_first_bits_out) && $stable(relay_second_bits_out))
    else $error("relay drive changed on write to another offset");

  a_relay_readback: assert property (s_read_at(oprb_pkg::OFF_RELAY_FIRST) |=>
    io_rvalid_out && (io_rdata_out == ~$past(relay_first_bits_out)))
    else $error("relay readback is not the complement of the drive");

  a_sensor_read_value: assert property (s_read_at(oprb_pkg::OFF_SENSOR_SECOND) |=>
    io_rdata_out == $past(sensor_second_bits_in))
    else $error("sensor read does not return the input level");

  a_zero_locations: assert property (io_rd_in && (io_addr_in == oprb_pkg::OFF_ZERO_FOUR
    || io_addr_in == oprb_pkg::OFF_ZERO_SIX || io_addr_in == oprb_pkg::OFF_ZERO_SEVEN)
    |=> io_rdata_out == oprb_pkg::READ_ZERO)
    else $error("spare location read non zero");

  a_ctrl_layout: assert property (s_read_at(oprb_pkg::OFF_IRQ_CTRL) |=>
    (io_rdata_out[5:2] == 4'h0) && (io_rdata_out[7] == $past(state.interrupt_enable_bit))
    && (io_rdata_out[6] == $past(state.interrupt_pending_bit)))
    else $error("control byte layout wrong");

  a_pending_read_clear: assert property (s_read_at(oprb_pkg::OFF_IRQ_CTRL) && !trig_event
    |=> !state.interrupt_pending_bit ##1 (state.interrupt_pending_bit == $past(trig_event)))
    else $error("pending not cleared by read");

  a_pending_not_written: assert property (wr_ctrl && !trig_event && !state.interrupt_pending_bit
    |=> !state.interrupt_pending_bit)
    else $error("pending bit was set by a write");

  a_level_holds: assert property (!state.trigger_type_select && !state.trigger_polarity_select
    && !sensor_first_bits_in[0] && !wr_ctrl |=> state.interrupt_pending_bit)
    else $error("low level trigger did not keep pending set");

  a_rising_edge: assert property (state.trigger_type_select && state.trigger_polarity_select
    && !wr_ctrl && $rose(sensor_first_bits_in[0]) |=> state.interrupt_pending_bit)
    else $error("rising edge did not set pending");

  a_request_gate: assert property (irq_out ==
    (state.interrupt_enable_bit && state.interrupt_pending_bit))
    else $error("request does not match enable and pending");

  a_sensor_read_first: assert property (s_read_at(oprb_pkg::OFF_SENSOR_FIRST) |=>
    io_rdata_out == $past(sensor_first_bits_in))
    else $error("first sensor group read does not return the input level");

  a_relay_readback_second: assert property (s_read_at(oprb_pkg::OFF_RELAY_SECOND) |=>
    io_rvalid_out && (io_rdata_out == ~$past(relay_second_bits_out)))
    else $error("second relay readback is not the complement of the drive");

  a_read_answer_once: assert property (!io_rd_in |=> !io_rvalid_out && $stable(io_rdata_out))
    else $error("read answer changed without a read");

  a_ctrl_mode_bits: assert property (s_read_at(oprb_pkg::OFF_IRQ_CTRL) |=>
    (io_rdata_out[oprb_pkg::BIT_TRIG_TYPE] == $past(state.trigger_type_select))
    && (io_rdata_out[oprb_pkg::BIT_TRIG_POL] == $past(state.trigger_polarity_select)))
    else $error("mode bits read back wrong");

  a_ctrl_write_fields: assert property (wr_ctrl |=>
    (state.interrupt_enable_bit == $past(io_wdata_in[oprb_pkg::BIT_IRQ_ENABLE]))
    && (state.trigger_type_select == $past(io_wdata_in[oprb_pkg::BIT_TRIG_TYPE]))
    && (state.trigger_polarity_select == $past(io_wdata_in[oprb_pkg::BIT_TRIG_POL])))
    else $error("control write did not set enable and mode");

  a_ctrl_held: assert property (!wr_ctrl |=> $stable(state.interrupt_enable_bit)
    && $stable(state.trigger_type_select) && $stable(state.trigger_polarity_select))
    else $error("enable or mode changed without a control write");

  a_pending_sticky: assert property (state.interrupt_pending_bit && !rd_ctrl |=>
    state.interrupt_pending_bit)
    else $error("pending cleared without a control read");

  a_high_level_holds: assert property (!state.trigger_type_select && state.trigger_polarity_select
    && sensor_first_bits_in[oprb_pkg::BIT_IRQ_SOURCE] && !wr_ctrl |=> state.interrupt_pending_bit)
    else $error("high level trigger did not keep pending set");

  a_falling_edge: assert property (state.trigger_type_select && !state.trigger_polarity_select
    && !wr_ctrl && $fell(sensor_first_bits_in[oprb_pkg::BIT_IRQ_SOURCE]) |=> state.interrupt_pending_bit)
    else $error("falling edge did not set pending");

  a_level_quiet: assert property (!state.trigger_type_select && !state.interrupt_pending_bit
    && (sensor_first_bits_in[oprb_pkg::BIT_IRQ_SOURCE] != state.trigger_polarity_select)
    |=> !state.interrupt_pending_bit)
    else $error("inactive level set pending");

  a_edge_needs_change: assert property (state.trigger_type_select && !state.interrupt_pending_bit
    && $stable(sensor_first_bits_in[oprb_pkg::BIT_IRQ_SOURCE]) |=> !state.interrupt_pending_bit)
    else $error("edge trigger set pending without a change");

  // Level mode with its source still at the active level
  sequence s_level_active;
    !state.trigger_type_select && !wr_ctrl
    && (sensor_first_bits_in[oprb_pkg::BIT_IRQ_SOURCE] == state.trigger_polarity_select);
  endsequence

  a_level_read_keeps: assert property (s_level_active ##0 s_read_at(oprb_pkg::OFF_IRQ_CTRL)
    |=> state.interrupt_pending_bit && (irq_out == state.interrupt_enable_bit))
    else $error("read cleared pending while the level still stood");

endmodule

//--- hdl/oprb_pkg.sv
// Shared constants of the opto relay port bank
package oprb_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 3;    // Eight byte locations
  localparam int unsigned DATA_W = 8;    // Every location is one byte

  // ---------------------------------------------------------------
  // Byte offsets from the card base address
  // ---------------------------------------------------------------
  localparam logic [2:0] OFF_SENSOR_FIRST  = 3'h0;
  localparam logic [2:0] OFF_SENSOR_SECOND = 3'h1;
  localparam logic [2:0] OFF_RELAY_FIRST   = 3'h2;
  localparam logic [2:0] OFF_RELAY_SECOND  = 3'h3;
  localparam logic [2:0] OFF_ZERO_FOUR     = 3'h4;
  localparam logic [2:0] OFF_IRQ_CTRL      = 3'h5;
  localparam logic [2:0] OFF_ZERO_SIX      = 3'h6;
  localparam logic [2:0] OFF_ZERO_SEVEN    = 3'h7;

  // ---------------------------------------------------------------
  // Interrupt control/status field positions
  // ---------------------------------------------------------------
  localparam int unsigned BIT_IRQ_ENABLE   = 7;
  localparam int unsigned BIT_IRQ_PENDING  = 6;
  localparam int unsigned BIT_TRIG_TYPE    = 1;  // 0 level, 1 edge
  localparam int unsigned BIT_TRIG_POL     = 0;  // 0 low/falling, 1 high/rising
  localparam int unsigned BIT_IRQ_SOURCE   = 0;  // Bit of first sensor port

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_RELAY    = 8'h00;  // All relays released
  localparam logic [1:0] RST_MODE     = 2'h0;
  localparam logic       RST_ENABLE   = 1'b0;
  localparam logic       RST_PENDING  = 1'b0;
  localparam logic       RST_SRC_PREV = 1'b1;  // Idle sensor reads high
  localparam logic [7:0] READ_ZERO    = 8'h00;

endpackage

//--- hdl/oprb_trigger.sv
// Trigger detector on the interrupt source bit
`timescale 1ns/1ns

module oprb_trigger
(
  // Clock and reset
  input  wire logic       clock_in,
  input  wire logic       arst_n_in,
  // Source and mode
  input  wire logic       src_in,
  input  wire logic       trig_type_in,
  input  wire logic       trig_pol_in,
  // Detected condition
  output logic            event_out
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed
  {
    logic src_prev;  // Source level one cycle ago
  } oprb_trig_state_t;

  oprb_trig_state_t state;       // Registered state
  oprb_trig_state_t next_state;  // Next state

  // Remembers the last source level for edge detection
  always_comb
  begin
    next_state          = state;
    next_state.src_prev = src_in;
  end

  // Level modes fire while the level holds, edge modes on a change
  always_comb
  begin
    if (!trig_type_in)
    begin
      // Level: low when polarity 0, high when polarity 1
      event_out = (src_in == trig_pol_in);
    end
    else
    begin
      // Edge: falling when polarity 0, rising when polarity 1
      event_out = (src_in == trig_pol_in) && (state.src_prev != trig_pol_in);
    end
  end

  // Registers the state
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state.src_prev <= oprb_pkg::RST_SRC_PREV;
    end
    else
    begin
      state <= next_state;
    end
  end

endmodule

//--- hdl/oprb_read_mux.sv
// Read data selection for the eight byte locations
`timescale 1ns/1ns

module oprb_read_mux
(
  // Selection
  input  wire logic [2:0] addr_in,
  // Sources
  input  wire logic [7:0] sensor_first_in,
  input  wire logic [7:0] sensor_second_in,
  input  wire logic [7:0] relay_first_in,
  input  wire logic [7:0] relay_second_in,
  input  wire logic [7:0] ctrl_in,
  // Selected byte
  output logic      [7:0] data_out
);

  // Picks one byte; relays read back inverted, spare locations zero
  always_comb
  begin
    case (addr_in)
      oprb_pkg::OFF_SENSOR_FIRST:  data_out = sensor_first_in;
      oprb_pkg::OFF_SENSOR_SECOND: data_out = sensor_second_in;
      oprb_pkg::OFF_RELAY_FIRST:   data_out = ~relay_first_in;
      oprb_pkg::OFF_RELAY_SECOND:  data_out = ~relay_second_in;
      oprb_pkg::OFF_IRQ_CTRL:      data_out = ctrl_in;
      default:                     data_out = oprb_pkg::READ_ZERO;
    endcase
  end

endmodule

//--- verif/oprb_host_model.sv
// Host side model that issues single byte reads and writes
`timescale 1ns/1ns

module oprb_host_model
(
  // Clock
  input  wire logic       clock_in,
  // Byte bus towards the bank
  output logic      [2:0] io_addr_out,
  output logic      [7:0] io_wdata_out,
  output logic            io_wr_out,
  output logic            io_rd_out,
  input  wire logic [7:0] io_rdata_in,
  input  wire logic       io_rvalid_in
);
  // Idle bus, no request pending
  initial
  begin
    io_addr_out  = 3'h0;
    io_wdata_out = 8'h00;
    io_wr_out    = 1'b0;
    io_rd_out    = 1'b0;
  end

  // One write strobe held across exactly one rising edge
  task automatic write_byte(input logic [2:0] addr, input logic [7:0] data);
    @(negedge clock_in);
    io_addr_out  = addr;
    io_wdata_out = data;
    io_wr_out    = 1'b1;
    @(negedge clock_in);
    io_wr_out    = 1'b0;
    io_wdata_out = ~data;  // Released data must not keep its last value
  endtask

  // One read strobe; the answer stands in the cycle after the taking edge
  task automatic read_byte(input logic [2:0] addr, output logic [7:0] data, output logic valid);
    @(negedge clock_in);
    io_addr_out = addr;
    io_rd_out   = 1'b1;
    @(negedge clock_in);
    io_rd_out   = 1'b0;
    data        = io_rdata_in;
    valid       = io_rvalid_in;
  endtask
endmodule

//--- verif/testbench.sv
// Self-checking bench for the opto relay port bank
`timescale 1ns/1ns

module testbench;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic       clock_in  = 1'b0;  // 100 MHz clock
  logic       arst_n_in = 1'b0;  // Reset, active low
  logic [2:0] io_addr;           // Bus from the host model
  logic [7:0] io_wdata;
  logic       io_wr;
  logic       io_rd;
  logic [7:0] io_rdata;          // Answers from the bank
  logic       io_rvalid;
  logic [7:0] sensor_first;      // Sensor levels, 1 idle
  logic [7:0] sensor_second;
  logic [7:0] relay_first;       // Relay drives, 1 closed
  logic [7:0] relay_second;
  logic       irq;               // Host interrupt request
  int         err_total = 0;     // Mismatches seen
  int         n_tests   = 0;     // Comparisons made

  // Clock generator
  always #5 clock_in = ~clock_in;

  // ---------------------------------------------------------------
  // Design and host model
  // ---------------------------------------------------------------
  oprb_port_bank dut
  (
    .clock_in              (clock_in),
    .arst_n_in             (arst_n_in),
    .io_addr_in            (io_addr),
    .io_wdata_in           (io_wdata),
    .io_wr_in              (io_wr),
    .io_rd_in              (io_rd),
    .io_rdata_out          (io_rdata),
    .io_rvalid_out         (io_rvalid),
    .sensor_first_bits_in  (sensor_first),
    .sensor_second_bits_in (sensor_second),
    .relay_first_bits_out  (relay_first),
    .relay_second_bits_out (relay_second),
    .irq_out               (irq)
  );

  oprb_host_model host
  (
    .clock_in     (clock_in),
    .io_addr_out  (io_addr),
    .io_wdata_out (io_wdata),
    .io_wr_out    (io_wr),
    .io_rd_out    (io_rd),
    .io_rdata_in  (io_rdata),
    .io_rvalid_in (io_rvalid)
  );

  // ---------------------------------------------------------------
  // Verdict and comparisons
  // ---------------------------------------------------------------
  task automatic stop_test();
    if (err_total == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Byte comparison
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Single bit comparison
  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  // Read one location and judge valid and data
  task automatic rd_chk(input logic [2:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    host.read_byte(addr, d, v);
    chk_bit(v, 1'b1, "read valid pulse");
    chk_byte(d, exp, "read data");
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // State straight after reset
  task automatic test_reset();
    chk_byte(relay_first, 8'h00, "relay first after reset");
    chk_byte(relay_second, 8'h00, "relay second after reset");
    chk_bit(irq, 1'b0, "request after reset");
    rd_chk(3'h5, 8'h00);
    rd_chk(3'h3, 8'hff);
  endtask

  // Sensor reads, refused writes, zero locations, relay drive
  task automatic test_ports();
    @(negedge clock_in);
    sensor_first  = 8'ha5;
    sensor_second = 8'h3c;
    rd_chk(3'h0, 8'ha5);
    rd_chk(3'h1, 8'h3c);
    host.write_byte(3'h0, 8'h5a);
    host.write_byte(3'h1, 8'hc3);
    host.write_byte(3'h4, 8'hff);
    host.write_byte(3'h6, 8'hff);
    host.write_byte(3'h7, 8'hff);
    rd_chk(3'h0, 8'ha5);
    rd_chk(3'h1, 8'h3c);
    rd_chk(3'h4, 8'h00);
    rd_chk(3'h6, 8'h00);
    rd_chk(3'h7, 8'h00);
    chk_byte(relay_first, 8'h00, "relay untouched");
    host.write_byte(3'h2, 8'h81);
    chk_byte(relay_first, 8'h81, "relay first drive");
    host.write_byte(3'h3, 8'h7e);
    chk_byte(relay_second, 8'h7e, "relay second drive");
    rd_chk(3'h2, 8'h7e);
    rd_chk(3'h3, 8'h81);
  endtask

  // One trigger mode: arm, fire, clear, release
  task automatic test_irq(input logic [1:0] m);
    logic [7:0] d;
    logic       v;
    logic       act;
    act = m[0];
    @(negedge clock_in);
    sensor_first[0] = ~act;
    host.write_byte(3'h5, {6'h00, m});
    host.read_byte(3'h5, d, v);
    host.write_byte(3'h5, 8'hc0 | {6'h00, m});
    rd_chk(3'h5, 8'h80 | {6'h00, m});
    @(negedge clock_in);
    sensor_first = {~sensor_first[7:1], ~act};
    sensor_second = ~sensor_second;
    repeat (3) @(negedge clock_in);
    chk_bit(irq, 1'b0, "other bits raise no request");
    sensor_first[0] = act;
    repeat (3) @(negedge clock_in);
    chk_bit(irq, 1'b1, "request on trigger");
    rd_chk(3'h5, 8'hc0 | {6'h00, m});
    if (m[1])
      rd_chk(3'h5, 8'h80 | {6'h00, m});
    else
      rd_chk(3'h5, 8'hc0 | {6'h00, m});
    chk_bit(irq, ~m[1], "request after first clear");
    sensor_first[0] = ~act;
    repeat (3) @(negedge clock_in);
    if (!m[1])
      rd_chk(3'h5, 8'hc0 | {6'h00, m});
    rd_chk(3'h5, 8'h80 | {6'h00, m});
    chk_bit(irq, 1'b0, "request gone");
    host.write_byte(3'h5, {6'h00, m});
  endtask

  // Pending sets while disabled but raises no request
  task automatic test_gate();
    host.write_byte(3'h5, 8'h00);
    @(negedge clock_in);
    sensor_first[0] = 1'b0;
    repeat (3) @(negedge clock_in);
    chk_bit(irq, 1'b0, "disabled gives no request");
    rd_chk(3'h5, 8'h40);
  endtask

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    sensor_first  = 8'hff;
    sensor_second = 8'hff;
    repeat (20) @(negedge clock_in);
    arst_n_in = 1'b1;
    test_reset();
    test_ports();
    for (int i = 0; i < 4; i++)
      test_irq(i[1:0]);
    test_gate();
    stop_test();
  end

  // Cuts a hang short well past the expected run length
  initial
  begin
    #200000;
    err_total++;
    stop_test();
  end
endmodule
